// ---- test/host_serial_model.sv ----
// Host-side serial terminal model that decodes characters from the device
`timescale 1ns/1ps
module host_serial_model #(
  parameter realtime bit_ns = 1600.0
) (
  // Serial pins seen from the host
  input wire logic txd_in,
  output logic rxd_out,
  // Decoded characters, newest in the low byte
  output logic [23:0] hist_out,
  output int cnt_out,
  output logic ferr_out
);
  logic [7:0] b;
  // Host idles high and sends only short bursts, never 64 unpaced
  initial rxd_out = 1'b1;
  // Send one character with eight data bits and one stop bit, LSB first
  task automatic send(input logic [7:0] c);
    rxd_out = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd_out = c[i];
      #(bit_ns);
    end
    rxd_out = 1'b1;
    #(bit_ns);
  endtask : send
  // Start with an empty history
  initial begin
    hist_out = 24'h000000;
    cnt_out = 0;
    ferr_out = 1'b0;
  end
  // Sample each bit at its middle, LSB first, eight data bits
  always begin
    @(negedge txd_in);
    #(bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd_in;
      #(bit_ns);
    end
    // Only one stop bit is sampled, so two stops also pass
    if (txd_in !== 1'b1) ferr_out = 1'b1;
    hist_out = {hist_out[15:0], b};
    cnt_out = cnt_out + 1;
  end
endmodule : host_serial_model

// ---- test/scpi_status_serial_handshake_tb.sv ----
// Testbench for the status, queue and serial handshake block
`timescale 1ns/1ps
module scpi_status_serial_handshake_tb;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic nv_rstn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  scpi_status_pkg::cmd_e cmd_code_in = scpi_status_pkg::CMD_EXT;
  logic [7:0] cmd_arg_in = 8'h00;
  logic cmd_src_in = 1'b0;
  logic exec_done_in = 1'b0;
  logic [3:0] err = 4'h0;
  logic quench_in = 1'b0;
  logic par_mav_in = 1'b0;
  logic sout_valid_in = 1'b0;
  logic sout_last_in = 1'b0;
  logic [7:0] sout_data_in = 8'h00;
  logic rx_ready_in = 1'b1;
  logic rxd_in, txd_out, cmd_ovf_out, exec_valid_out, exec_src_out;
  logic resp_valid_out, resp_src_out, par_opc_out, sout_ready_out;
  logic rx_valid_out, rx_term_out, ferr;
  logic [7:0] exec_arg_out, resp_data_out, rx_data_out, stb_out, esr_out;
  logic [7:0] ese_out;
  logic [23:0] hist;
  int cnt, n_ovf = 0, error_cnt = 0, n_tests = 0;

  // Clock of 100 ns period
  always #50 mclk_in = ~mclk_in;

  // Small divider keeps each bit at 16 clocks
  scpi_status_serial_handshake #(.div_1200(16)) u_dut (
    .mclk_in, .rstn_in, .nv_rstn_in, .ce_in(1'b1), .baud_sel_in(2'h0),
    .fmt_sel_in(scpi_status_pkg::FMT_NONE8), .two_stop_in(1'b0),
    .flow_en_in(1'b0), .rxd_in, .txd_out, .cmd_valid_in, .cmd_code_in,
    .cmd_arg_in, .cmd_src_in, .cmd_ovf_out, .exec_valid_out, .exec_arg_out,
    .exec_src_out, .exec_done_in, .err_query_in(err[0]),
    .err_device_in(err[1]), .err_exec_in(err[2]), .err_cmd_in(err[3]),
    .resp_valid_out, .resp_data_out, .resp_src_out, .par_opc_out,
    .sout_valid_in, .sout_data_in, .sout_last_in, .sout_ready_out,
    .rx_valid_out, .rx_data_out, .rx_term_out, .rx_ready_in, .quench_in,
    .par_mav_in, .stb_out, .esr_out, .ese_out);

  host_serial_model #(.bit_ns(1600.0)) u_host (.txd_in(txd_out),
    .rxd_out(rxd_in), .hist_out(hist), .cnt_out(cnt), .ferr_out(ferr));

  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  // A used-up wait bound is a mismatch and ends the run
  task automatic lim(input int i, input int n);
    chk(24'(i >= n), 24'h0);
    if (i >= n) end_sim();
  endtask : lim

  // Push one command; keep valid high for back-to-back pushes
  task automatic cmd(input scpi_status_pkg::cmd_e c, input logic [7:0] a,
                     input bit keep = 1'b0);
    cmd_code_in = c;
    cmd_arg_in = a;
    cmd_valid_in = 1'b1;
    #1;
    if (cmd_ovf_out === 1'b1) n_ovf++;
    tick(1);
    if (!keep) cmd_valid_in = 1'b0;
  endtask : cmd

  task automatic query(input scpi_status_pkg::cmd_e c, input logic [7:0] e);
    int i;
    cmd(c, 8'h00);
    for (i = 0; i < 20 && resp_valid_out !== 1'b1; i++) tick(1);
    lim(i, 20);
    chk(resp_data_out, e);
  endtask : query

  // Wait until the host has decoded n characters in total
  task automatic host(input int n);
    int i;
    for (i = 0; i < 2000 && cnt < n; i++) tick(1);
    lim(i, 2000);
  endtask : host

  initial begin
    int i;
    int k;
    tick(16);
    rstn_in = 1'b1;
    nv_rstn_in = 1'b1;
    tick(2);
    chk(esr_out, 8'h80);
    chk(ese_out, 8'h00);
    query(scpi_status_pkg::CMD_ESR_Q, 8'h80);
    tick(1);
    chk(esr_out, 8'h00);
    // Each error source alone, cleared again by the event read
    for (k = 0; k < 4; k++) begin
      err = 4'h1 << k;
      tick(1);
      err = 4'h0;
      tick(1);
      chk(esr_out, 8'h04 << k);
      query(scpi_status_pkg::CMD_ESR_Q, 8'h04 << k);
    end
    // One executing command, then a full queue and one more
    cmd(scpi_status_pkg::CMD_EXT, 8'h01);
    tick(3);
    for (k = 2; k < 5; k++) cmd(scpi_status_pkg::CMD_EXT, 8'(k), 1'b1);
    cmd(scpi_status_pkg::CMD_OPC, 8'h00, 1'b1);
    cmd(scpi_status_pkg::CMD_EXT, 8'h06);
    chk(n_ovf, 1);
    for (k = 1; k < 5; k++) begin
      for (i = 0; i < 20 && exec_valid_out !== 1'b1; i++) tick(1);
      lim(i, 20);
      chk(exec_arg_out, k);
      chk(esr_out[0], 1'b0);
      exec_done_in = 1'b1;
      tick(1);
      exec_done_in = 1'b0;
      tick(1);
    end
    tick(3);
    chk(esr_out, 8'h11);
    // Mask survives a power cycle when the clear setting is 0
    cmd(scpi_status_pkg::CMD_PSC_W, 8'h00, 1'b1);
    cmd(scpi_status_pkg::CMD_ESE_W, 8'h24);
    tick(3);
    query(scpi_status_pkg::CMD_PSC_Q, 8'h00);
    rstn_in = 1'b0;
    tick(2);
    rstn_in = 1'b1;
    tick(2);
    chk({ese_out, esr_out, stb_out}, 24'h248000);
    err = 4'hF;
    tick(1);
    err = 4'h0;
    tick(1);
    chk(esr_out, 8'hBC);
    chk(stb_out[5], 1'b1);
    cmd(scpi_status_pkg::CMD_CLS, 8'h00);
    tick(3);
    chk({esr_out, 7'h00, stb_out[5]}, 16'h0000);
    cmd(scpi_status_pkg::CMD_ESE_W, 8'h00);
    tick(3);
    chk(ese_out, 8'h00);
    quench_in = 1'b1;
    par_mav_in = 1'b1;
    tick(1);
    chk(stb_out & 8'h1C, 8'h14);
    par_mav_in = 1'b0;
    // One response byte, then the completion query answer
    sout_data_in = 8'h41;
    sout_last_in = 1'b1;
    sout_valid_in = 1'b1;
    for (i = 0; i < 20 && sout_ready_out !== 1'b1; i++) tick(1);
    lim(i, 20);
    tick(1);
    sout_valid_in = 1'b0;
    chk(stb_out[3], 1'b1);
    host(3);
    chk(hist, {8'h41, scpi_status_pkg::CH_CR,
               scpi_status_pkg::CH_LF});
    tick(20);
    chk(stb_out[3], 1'b0);
    cmd(scpi_status_pkg::CMD_OPC_Q, 8'h00);
    host(6);
    chk(hist, 24'h310D0A);
    chk({esr_out[0], ferr}, 2'h0);
    // Received command: CR marks the end, the LF after it is folded away
    rx_ready_in = 1'b0;
    u_host.send(8'h41);
    u_host.send(scpi_status_pkg::CH_CR);
    u_host.send(scpi_status_pkg::CH_LF);
    tick(40);
    chk({rx_valid_out, rx_term_out, rx_data_out}, 24'h000241);
    rx_ready_in = 1'b1;
    tick(1);
    rx_ready_in = 1'b0;
    chk({rx_valid_out, rx_term_out, rx_data_out}, 24'h00030D);
    rx_ready_in = 1'b1;
    tick(1);
    chk(rx_valid_out, 1'b0);
    end_sim();
  end
endmodule : scpi_status_serial_handshake_tb

// ---- verilog/scpi_status_pkg.sv ----
// Shared constants and types for the status, queue and serial handshake block
package scpi_status_pkg;

  // Clock rate and serial bit timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_BAUD = 1200;
  localparam int unsigned BAUD_DIV_1200 = CLK_HZ / SLOW_BAUD;
  localparam int CNT_W = 14;

  // Standard event bit positions
  localparam int EV_OPC = 0;
  localparam int EV_QUERY = 2;
  localparam int EV_DEVICE = 3;
  localparam int EV_EXEC = 4;
  localparam int EV_CMD = 5;
  localparam int EV_PWR = 7;
  localparam logic [7:0] EV_USED = 8'hBD;
  localparam logic [7:0] ESR_RESET = 8'h80;

  // Status byte bit positions
  localparam int SB_QUENCH = 2;
  localparam int SB_SER_MAV = 3;
  localparam int SB_PAR_MAV = 4;
  localparam int SB_EVENT = 5;

  // Queue and buffer sizes
  localparam int CMDQ_DEPTH = 4;
  localparam int TXB_DEPTH = 16;
  localparam int RXB_DEPTH = 8;
  localparam int RX_HIGH = 6;
  localparam int RX_LOW = 2;

  // Reset values of the persistent settings
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic PSC_RESET = 1'b1;

  // Characters
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_ONE = 8'h31;

  // Character formats
  localparam logic [1:0] FMT_EVEN7 = 2'h0;
  localparam logic [1:0] FMT_ODD7 = 2'h1;
  localparam logic [1:0] FMT_NONE8 = 2'h2;

  // Commands taken by the queue
  typedef enum logic [3:0] {
    CMD_EXT, CMD_CLS, CMD_ESR_Q, CMD_OPC, CMD_OPC_Q,
    CMD_ESE_W, CMD_ESE_Q, CMD_PSC_W, CMD_PSC_Q
  } cmd_e;

endpackage : scpi_status_pkg

// ---- verilog/scpi_status_serial_handshake.sv ----
// Status registers, command queue and serial port with flow control
// What this block does
// - Message-available bits stay set until buffer read
// - Clear status or event read clears event register
// - Mask clears on zero write, or power-up with setting
// - Enabled set event reported into status byte
// - Completion command sets bit 0 after earlier commands
// - Event bits 1 and 6 always read zero
// - Query error sets event bit 2
// - Device error sets event bit 3
// - Execution error sets event bit 4
// - Command error sets event bit 5
// - Bit 7 set at power-up until read
// - Four-entry command queue, executed in order
// - Command into full queue dropped, overflow logged
// - Completion query answers 1 to requesting port
// - Bit rates 1200, 2400, 4800, 9600
// - Formats even7, odd7 or none8
// - One start bit, one or two stops
// - Serial responses end with CR then LF
// - CR, LF, pairs or semicolon terminate commands
// - Pause on 0x13, resume on 0x11
// - Send pause at high water, resume later
// - Overflow never causes pause or resume characters
// - Status bit 5 summarises enabled events
// - Status bit 3 shows unread serial output
`timescale 1ns/1ps
module scpi_status_serial_handshake #(
  parameter int unsigned div_1200 = scpi_status_pkg::BAUD_DIV_1200
) (
  // Clock, resets, enable
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic nv_rstn_in,
  input wire logic ce_in,
  // Serial port settings
  input wire logic [1:0] baud_sel_in,
  input wire logic [1:0] fmt_sel_in,
  input wire logic two_stop_in,
  input wire logic flow_en_in,
  // Serial pins
  input wire logic rxd_in,
  output logic txd_out,
  // Command queue
  input wire logic cmd_valid_in,
  input wire scpi_status_pkg::cmd_e cmd_code_in,
  input wire logic [7:0] cmd_arg_in,
  input wire logic cmd_src_in,
  output logic cmd_ovf_out,
  // Execution of external commands
  output logic exec_valid_out,
  output logic [7:0] exec_arg_out,
  output logic exec_src_out,
  input wire logic exec_done_in,
  // Error events from the parser and executor
  input wire logic err_query_in,
  input wire logic err_device_in,
  input wire logic err_exec_in,
  input wire logic err_cmd_in,
  // Query answers
  output logic resp_valid_out,
  output logic [7:0] resp_data_out,
  output logic resp_src_out,
  output logic par_opc_out,
  // Serial response bytes
  input wire logic sout_valid_in,
  input wire logic [7:0] sout_data_in,
  input wire logic sout_last_in,
  output logic sout_ready_out,
  // Received serial command bytes
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_term_out,
  input wire logic rx_ready_in,
  // Status
  input wire logic quench_in,
  input wire logic par_mav_in,
  output logic [7:0] stb_out,
  output logic [7:0] esr_out,
  output logic [7:0] ese_out
);

  typedef enum {X_IDLE, X_EXT, X_OPCQ} exec_e;
  typedef enum {G_PASS, G_ONE, G_CR, G_LF} gen_e;

  // Clocks per bit for the selected rate, halving per step
  function automatic logic [13:0] div_of(input logic [1:0] sel);
    div_of = 14'(div_1200 >> sel);
  endfunction : div_of

  // Parity of seven data bits, odd or even
  function automatic logic par_of(input logic [6:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of

  logic [7:0] esr_q, esr_d, mask_q;
  logic psc_q, por_q, esr_clr, opc_set, ovf;
  logic [3:0] q_code [scpi_status_pkg::CMDQ_DEPTH];
  logic [7:0] q_arg [scpi_status_pkg::CMDQ_DEPTH];
  logic q_src [scpi_status_pkg::CMDQ_DEPTH];
  logic [1:0] q_wr_q, q_rd_q;
  logic [2:0] q_cnt_q;
  logic q_push, q_pop;
  scpi_status_pkg::cmd_e head_code;
  exec_e x_q;
  gen_e gen_q, gen_d;
  logic [7:0] tb_mem [scpi_status_pkg::TXB_DEPTH];
  logic [3:0] tb_wr_q, tb_rd_q;
  logic [4:0] tb_cnt_q;
  logic tb_wr, tb_rd;
  logic [7:0] tb_byte;
  logic halt_q, xoff_pend_q, xon_pend_q, xoff_sent_q;
  logic tx_busy_q, tx_data_q, tx_go;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_n_q;
  logic [13:0] tx_cnt_q;
  logic rx1_q, rx2_q, rx3_q, rx_lvl_q, rx_on_q, rx_done;
  logic [9:0] rx_sh_q;
  logic [3:0] rx_n_q;
  logic [13:0] rx_cnt_q;
  logic [7:0] rx_byte;
  logic [8:0] rb_mem [scpi_status_pkg::RXB_DEPTH];
  logic [2:0] rb_wr_q, rb_rd_q;
  logic [3:0] rb_cnt_q;
  logic rb_wr, rb_rd, last_cr_q, last_lf_q, is_cr, is_lf;

  assign head_code = scpi_status_pkg::cmd_e'(q_code[q_rd_q]);
  assign q_pop = (x_q == X_IDLE) && (q_cnt_q != 3'h0);

  // Command queue: arrival order, a full queue drops the newcomer
  assign ovf = cmd_valid_in && (q_cnt_q == 3'(scpi_status_pkg::CMDQ_DEPTH));
  assign q_push = cmd_valid_in && !ovf;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_wr_q <= 2'h0;
      q_rd_q <= 2'h0;
      q_cnt_q <= 3'h0;
    end else if (ce_in) begin
      if (q_push) begin
        q_code[q_wr_q] <= cmd_code_in;
        q_arg[q_wr_q] <= cmd_arg_in;
        q_src[q_wr_q] <= cmd_src_in;
        q_wr_q <= q_wr_q + 2'h1;
      end
      if (q_pop) q_rd_q <= q_rd_q + 2'h1;
      q_cnt_q <= q_cnt_q + 3'(q_push) - 3'(q_pop);
    end
  end

  // Executor: one command at a time, so earlier ones finish first
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      x_q <= X_IDLE;
      exec_arg_out <= 8'h00;
      exec_src_out <= 1'b0;
    end else if (ce_in) begin
      unique case (x_q)
        X_IDLE: if (q_pop) begin
          exec_arg_out <= q_arg[q_rd_q];
          exec_src_out <= q_src[q_rd_q];
          if (head_code == scpi_status_pkg::CMD_EXT) x_q <= X_EXT;
          else if (head_code == scpi_status_pkg::CMD_OPC_Q && !q_src[q_rd_q])
            x_q <= X_OPCQ;
        end
        X_EXT: if (exec_done_in) x_q <= X_IDLE;
        X_OPCQ: if (gen_q == G_PASS) x_q <= X_IDLE;
      endcase
    end
  end
  assign exec_valid_out = (x_q == X_EXT);
  assign cmd_ovf_out = ovf;

  // Internal commands take effect in the cycle they leave the queue
  assign opc_set = q_pop && head_code == scpi_status_pkg::CMD_OPC;
  assign esr_clr = q_pop && (head_code == scpi_status_pkg::CMD_CLS ||
                   head_code == scpi_status_pkg::CMD_ESR_Q);

  // Event latch: a set in the clearing cycle survives the clear
  always_comb begin
    esr_d = esr_clr ? 8'h00 : esr_q;
    esr_d[scpi_status_pkg::EV_OPC] |= opc_set;
    esr_d[scpi_status_pkg::EV_QUERY] |= err_query_in;
    esr_d[scpi_status_pkg::EV_DEVICE] |= err_device_in;
    esr_d[scpi_status_pkg::EV_EXEC] |= err_exec_in | ovf;
    esr_d[scpi_status_pkg::EV_CMD] |= err_cmd_in;
    esr_d = esr_d & scpi_status_pkg::EV_USED;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) esr_q <= scpi_status_pkg::ESR_RESET;
    else if (ce_in) esr_q <= esr_d;
  end

  // Power-up marker, high for the first enabled cycle after reset
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) por_q <= 1'b1;
    else if (ce_in) por_q <= 1'b0;
  end

  // Mask and clear setting live on the battery reset, not power reset
  always_ff @(posedge mclk_in or negedge nv_rstn_in) begin
    if (!nv_rstn_in) begin
      mask_q <= scpi_status_pkg::MASK_RESET;
      psc_q <= scpi_status_pkg::PSC_RESET;
    end else if (ce_in) begin
      if (por_q && psc_q) mask_q <= 8'h00;
      else if (q_pop && head_code == scpi_status_pkg::CMD_ESE_W)
        mask_q <= q_arg[q_rd_q];
      if (q_pop && head_code == scpi_status_pkg::CMD_PSC_W)
        psc_q <= q_arg[q_rd_q][0];
    end
  end

  // Query answers for the outside formatter
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out <= 8'h00;
      resp_src_out <= 1'b0;
      par_opc_out <= 1'b0;
    end else if (ce_in) begin
      resp_valid_out <= q_pop && (head_code == scpi_status_pkg::CMD_ESR_Q ||
                        head_code == scpi_status_pkg::CMD_ESE_Q ||
                        head_code == scpi_status_pkg::CMD_PSC_Q);
      resp_src_out <= q_src[q_rd_q];
      unique case (head_code)
        scpi_status_pkg::CMD_ESE_Q: resp_data_out <= mask_q;
        scpi_status_pkg::CMD_PSC_Q: resp_data_out <= {7'h00, psc_q};
        default: resp_data_out <= esr_q;
      endcase
      par_opc_out <= q_pop && head_code == scpi_status_pkg::CMD_OPC_Q &&
                     q_src[q_rd_q];
    end
  end

  // Status byte: summary and message-available bits
  assign stb_out = {2'b00, |(esr_q & mask_q), par_mav_in,
    (tb_cnt_q != 5'h00) || tx_data_q || gen_q != G_PASS,
    quench_in, 2'b00};
  assign esr_out = esr_q;
  assign ese_out = mask_q;

  // Response generator appends CR LF to every serial answer
  assign sout_ready_out = gen_q == G_PASS && x_q != X_OPCQ &&
                          tb_cnt_q != 5'(scpi_status_pkg::TXB_DEPTH);
  always_comb begin
    gen_d = gen_q;
    tb_wr = 1'b0;
    tb_byte = sout_data_in;
    unique case (gen_q)
      G_PASS: if (x_q == X_OPCQ) gen_d = G_ONE;
        else if (sout_valid_in && sout_ready_out) begin
          tb_wr = 1'b1;
          if (sout_last_in) gen_d = G_CR;
        end
      G_ONE: begin
        tb_byte = scpi_status_pkg::CH_ONE;
        gen_d = G_CR;
      end
      G_CR: begin
        tb_byte = scpi_status_pkg::CH_CR;
        gen_d = G_LF;
      end
      G_LF: begin
        tb_byte = scpi_status_pkg::CH_LF;
        gen_d = G_PASS;
      end
    endcase
    if (gen_q != G_PASS) begin
      if (tb_cnt_q == 5'(scpi_status_pkg::TXB_DEPTH)) gen_d = gen_q;
      else tb_wr = 1'b1;
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) gen_q <= G_PASS;
    else if (ce_in) gen_q <= gen_d;
  end

  // Serial output buffer
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tb_wr_q <= 4'h0;
      tb_rd_q <= 4'h0;
      tb_cnt_q <= 5'h00;
    end else if (ce_in) begin
      if (tb_wr) begin
        tb_mem[tb_wr_q] <= tb_byte;
        tb_wr_q <= tb_wr_q + 4'h1;
      end
      if (tb_rd) tb_rd_q <= tb_rd_q + 4'h1;
      tb_cnt_q <= tb_cnt_q + 5'(tb_wr) - 5'(tb_rd);
    end
  end

  // Transmitter: flow characters bypass a halt, data waits at a boundary
  assign tx_go = !tx_busy_q;
  assign tb_rd = tx_go && !(flow_en_in && (xoff_pend_q || xon_pend_q)) &&
                 !halt_q && tb_cnt_q != 5'h00;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_busy_q <= 1'b0;
      tx_data_q <= 1'b0;
      tx_sh_q <= 12'hFFF;
      tx_n_q <= 4'h0;
      tx_cnt_q <= 14'h0000;
      txd_out <= 1'b1;
    end else if (ce_in) begin
      if (tx_go) begin
        tx_cnt_q <= 14'h0000;
        tx_n_q <= two_stop_in ? 4'hB : 4'hA;
        tx_data_q <= tb_rd;
        tx_busy_q <= tb_rd || (flow_en_in && (xoff_pend_q || xon_pend_q));
        tx_sh_q <= 12'hFFF;
        if (tx_busy_q == 1'b0) begin
          logic [7:0] b;
          b = !flow_en_in ? tb_mem[tb_rd_q] :
              xoff_pend_q ? scpi_status_pkg::CH_XOFF :
              xon_pend_q ? scpi_status_pkg::CH_XON : tb_mem[tb_rd_q];
          tx_sh_q <= {2'b11, (fmt_sel_in == scpi_status_pkg::FMT_NONE8) ?
                      b[7] : par_of(b[6:0], fmt_sel_in[0]),
                      b[6:0], 1'b0};
        end
      end else if (tx_cnt_q == 14'h0000) begin
        if (tx_n_q == 4'h0) begin
          tx_busy_q <= 1'b0;
          tx_data_q <= 1'b0;
        end else begin
          txd_out <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[11:1]};
          tx_n_q <= tx_n_q - 4'h1;
          tx_cnt_q <= div_of(baud_sel_in) - 14'h0001;
        end
      end else tx_cnt_q <= tx_cnt_q - 14'h0001;
    end
  end

  // Receive pin: three flops, a change counts when the last two agree
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
      rx3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else if (ce_in) begin
      rx1_q <= rxd_in;
      rx2_q <= rx1_q;
      rx3_q <= rx2_q;
      if (rx2_q == rx3_q) rx_lvl_q <= rx3_q;
    end
  end

  // Receiver samples start, eight data or parity bits and a stop mid-bit
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_on_q <= 1'b0;
      rx_sh_q <= 10'h000;
      rx_n_q <= 4'h0;
      rx_cnt_q <= 14'h0000;
    end else if (ce_in) begin
      if (!rx_on_q) begin
        rx_n_q <= 4'h0;
        rx_cnt_q <= div_of(baud_sel_in) >> 1;
        rx_on_q <= !rx_lvl_q;
      end else if (rx_cnt_q == 14'h0000) begin
        rx_sh_q <= {rx_lvl_q, rx_sh_q[9:1]};
        rx_n_q <= rx_n_q + 4'h1;
        rx_cnt_q <= div_of(baud_sel_in) - 14'h0001;
        if ((rx_n_q == 4'h0 && rx_lvl_q) || rx_n_q == 4'h9) rx_on_q <= 1'b0;
      end else rx_cnt_q <= rx_cnt_q - 14'h0001;
    end
  end
  assign rx_byte = (fmt_sel_in == scpi_status_pkg::FMT_NONE8) ?
                   rx_sh_q[8:1] : {1'b0, rx_sh_q[7:1]};
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) rx_done <= 1'b0;
    else if (ce_in) rx_done <= rx_on_q && rx_cnt_q == 14'h0000 &&
      rx_n_q == 4'h9 && rx_lvl_q && !rx_sh_q[1] &&
      (fmt_sel_in == scpi_status_pkg::FMT_NONE8 ||
       rx_sh_q[9] == par_of(rx_sh_q[8:2], fmt_sel_in[0]));
  end

  // Fold CR LF and LF CR pairs into one terminator
  assign is_cr = rx_byte == scpi_status_pkg::CH_CR;
  assign is_lf = rx_byte == scpi_status_pkg::CH_LF;
  assign rb_wr = rx_done && rb_cnt_q != 4'(scpi_status_pkg::RXB_DEPTH) &&
    !(flow_en_in && (rx_byte == scpi_status_pkg::CH_XOFF ||
      rx_byte == scpi_status_pkg::CH_XON)) &&
    !(is_cr && last_lf_q) && !(is_lf && last_cr_q);
  assign rb_rd = rx_ready_in && rb_cnt_q != 4'h0;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rb_wr_q <= 3'h0;
      rb_rd_q <= 3'h0;
      rb_cnt_q <= 4'h0;
      last_cr_q <= 1'b0;
      last_lf_q <= 1'b0;
    end else if (ce_in) begin
      if (rx_done) begin
        last_cr_q <= is_cr && !last_lf_q;
        last_lf_q <= is_lf && !last_cr_q;
      end
      if (rb_wr) begin
        rb_mem[rb_wr_q] <= {is_cr || is_lf ||
          rx_byte == scpi_status_pkg::CH_SEMI, rx_byte};
        rb_wr_q <= rb_wr_q + 3'h1;
      end
      if (rb_rd) rb_rd_q <= rb_rd_q + 3'h1;
      rb_cnt_q <= rb_cnt_q + 4'(rb_wr) - 4'(rb_rd);
    end
  end
  assign rx_valid_out = rb_cnt_q != 4'h0;
  assign {rx_term_out, rx_data_out} = rb_mem[rb_rd_q];

  // Flow control: halt on 0x13, resume on 0x11; pause or resume the host
  // from buffer level only, so queue overflow never produces them
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halt_q <= 1'b0;
      xoff_pend_q <= 1'b0;
      xon_pend_q <= 1'b0;
      xoff_sent_q <= 1'b0;
    end else if (ce_in) begin
      if (!flow_en_in) halt_q <= 1'b0;
      else if (rx_done && rx_byte == scpi_status_pkg::CH_XOFF) halt_q <= 1'b1;
      else if (rx_done && rx_byte == scpi_status_pkg::CH_XON)
        halt_q <= 1'b0;
      if (tx_go && flow_en_in && xoff_pend_q) xoff_pend_q <= 1'b0;
      else if (tx_go && flow_en_in && xon_pend_q) xon_pend_q <= 1'b0;
      if (flow_en_in && !xoff_sent_q &&
          rb_cnt_q >= 4'(scpi_status_pkg::RX_HIGH)) begin
        xoff_sent_q <= 1'b1;
        xoff_pend_q <= 1'b1;
        xon_pend_q <= 1'b0;
      end else if (xoff_sent_q &&
                   rb_cnt_q <= 4'(scpi_status_pkg::RX_LOW)) begin
        xoff_sent_q <= 1'b0;
        xon_pend_q <= flow_en_in;
        xoff_pend_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_unused_zero: assert property (!esr_q[1] && !esr_q[6])
    else $error("unused event bits set");
  a_event_clear: assert property (ce_in && esr_clr && !ovf && !err_exec_in &&
    !err_query_in && !err_device_in && !err_cmd_in |=> esr_q == 8'h00)
    else $error("event register not cleared");
  a_opc_sets: assert property (ce_in && opc_set |=> esr_q[0])
    else $error("completion bit not set");
  a_err_bits: assert property (ce_in && err_query_in && err_device_in |=>
    esr_q[2] && esr_q[3])
    else $error("query or device error bit missing");
  a_exec_cmd: assert property (ce_in && (err_exec_in || ovf) && err_cmd_in
    |=> esr_q[4] && esr_q[5])
    else $error("execution or command error bit missing");
  a_power_hold: assert property (ce_in && esr_q[7] && !esr_clr |=> esr_q[7])
    else $error("power-on bit lost");
  a_queue_drop: assert property (ce_in && ovf && !q_pop |=>
    q_cnt_q == 3'h4 && $stable(q_wr_q))
    else $error("overflowed command stored");
  a_mav_held: assert property (tb_cnt_q != 5'h00 |-> stb_out[3])
    else $error("serial message bit dropped");
  a_summary_bit: assert property (ce_in && esr_d[2] && mask_q[2] &&
    !por_q |=> stb_out[5])
    else $error("enabled event not summarised");
  a_halt_hold: assert property (halt_q && !tx_busy_q |-> !tb_rd)
    else $error("data sent while halted");
  a_crlf_seq: assert property (ce_in && gen_q == G_CR && tb_wr |=>
    gen_q == G_LF)
    else $error("line feed does not follow return");

  c_overflow: cover property (ce_in && ovf);
  c_opc_query: cover property (x_q == X_OPCQ ##[1:5] gen_q == G_LF);
  c_halted_tx: cover property (halt_q && tb_cnt_q != 5'h00);

endmodule : scpi_status_serial_handshake
